// [hw/timer8_pkg.sv]
// constants, types and register map for the 8-bit waveform timer
// Contract
// - a nonzero output mode field hands the pin to the compare output; modes 4 and 6 and off or reserved PWM code 01 keep the port
// - non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match
// - non-PWM channel B decodes the same four settings as channel A
// - PWM channel A field 01: off if top mode bit 0, toggle if 1
// - fast PWM A: 10 clear on match, set at BOTTOM; 11 the inverse
// - fast PWM B: 01 reserved; 10 and 11 as channel A
// - phase PWM A: 10 clear on up match, set on down; 11 inverse
// - phase PWM B: 01 reserved; 10 and 11 as channel A
// - fast PWM, compare equals TOP: ignore match, act only at BOTTOM
// - phase PWM, compare equals TOP: ignore match, act at TOP
// - control bits 3 and 2 read zero and ignore writes
// - waveform mode is two low bits plus companion top mode bit
// - mode table 0..7 with TOP 0xFF or compare A; 4 and 6 reserved
// - compare update and overflow flag point follow the mode table
package timer8_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hB4;
  localparam logic [7:0] ADDR_CMP_A  = 8'hB8;
  localparam logic [7:0] ADDR_CMP_B  = 8'hBC;
  localparam logic [7:0] ADDR_COUNT  = 8'hC0;
  localparam logic [7:0] ADDR_STATUS = 8'hC4;
  localparam logic [7:0] ADDR_MASK   = 8'hC8;

  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam int         COM_A_POS    = 6;
  localparam int         COM_B_POS    = 4;
  localparam int         TOP_BIT_POS  = 3;
  localparam int         STAT_OVF     = 0;
  localparam int         STAT_MATCH_A = 1;
  localparam int         STAT_MATCH_B = 2;

  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // ----------------------------------------------------------------
  // waveform modes and output mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PHASE_FF = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_FF  = 3'h3;
  localparam logic [2:0] MODE_RSV_4    = 3'h4;
  localparam logic [2:0] MODE_PHASE_A  = 3'h5;
  localparam logic [2:0] MODE_RSV_6    = 3'h6;
  localparam logic [2:0] MODE_FAST_A   = 3'h7;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef enum logic {COUNT_UP = 1'b0, COUNT_DOWN = 1'b1} dir_type;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic       top_bit;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] count;
    logic       count_written;
    dir_type    dir;
    logic [1:0] oc;
    logic [1:0] pin;
    logic [1:0] pin_oe_n;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] rdata;
  } state_type;

endpackage : timer8_pkg

// [hw/timer8_wave.sv]
// 8-bit timer with two compare outputs and waveform mode control
`timescale 1ns/1ps
module timer8_wave
  import timer8_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       port_data_a,
  input  wire logic       port_data_b,
  input  wire logic       port_dir_a,
  input  wire logic       port_dir_b,
  output logic            compare_output_pin_a,
  output logic            compare_output_pin_b,
  output logic            pin_oe_n_a,
  output logic            pin_oe_n_b,
  output logic            irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic reset_meta;
  logic reset_sync_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_meta   <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta   <= 1'b1;
      reset_sync_n <= reset_meta;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  state_type       cur;
  state_type       next_state;
  logic      [2:0] waveform_mode_select;
  logic            mode_fast;
  logic            mode_phase;
  logic            mode_plain;
  logic            mode_rsv;
  logic      [7:0] top_value;
  logic            at_top;
  logic            at_bottom;
  logic [1:0][1:0] com_sel;
  logic [1:0][7:0] cmp_sel;
  logic      [1:0] match;
  logic      [1:0] link;
  logic      [1:0] next_oc;
  logic      [1:0] port_data;
  logic      [1:0] port_dir;

  assign waveform_mode_select = {cur.top_bit, cur.ctrl_a[1:0]};
  assign mode_fast  = (waveform_mode_select == MODE_FAST_FF) ||
                      (waveform_mode_select == MODE_FAST_A);
  assign mode_phase = (waveform_mode_select == MODE_PHASE_FF) ||
                      (waveform_mode_select == MODE_PHASE_A);
  assign mode_plain = (waveform_mode_select == MODE_NORMAL) ||
                      (waveform_mode_select == MODE_CTC);
  // reserved modes count like normal mode but never link a pin, so a
  // stray setting cannot drive an undefined waveform onto the port
  assign mode_rsv   = (waveform_mode_select == MODE_RSV_4) ||
                      (waveform_mode_select == MODE_RSV_6);

  // compare A becomes TOP in modes 2, 5 and 7
  always_comb begin
    case (waveform_mode_select)
      MODE_CTC, MODE_PHASE_A, MODE_FAST_A: top_value = cur.cmp_a;
      default:                             top_value = COUNT_MAX;
    endcase
  end

  assign at_top    = (cur.count == top_value);
  assign at_bottom = (cur.count == COUNT_BOTTOM);

  assign com_sel   = {cur.ctrl_a[COM_B_POS +: 2], cur.ctrl_a[COM_A_POS +: 2]};
  assign cmp_sel   = {cur.cmp_b, cur.cmp_a};
  assign port_data = {port_data_b, port_data_a};
  assign port_dir  = {port_dir_b, port_dir_a};

  // ----------------------------------------------------------------
  // per-channel output waveform
  // ----------------------------------------------------------------
  // both channels share one decode; only the reserved PWM code 01
  // differs, and it is told apart by the channel index
  for (genvar i = 0; i < 2; i++) begin : chan
    logic eq_top;
    assign eq_top = (cmp_sel[i] == top_value);
    // a counter write masks the match on the next cycle
    assign match[i] = (cur.count == cmp_sel[i]) && !cur.count_written;

    always_comb begin
      link[i]    = 1'b0;
      next_oc[i] = cur.oc[i];
      if (com_sel[i] != COM_OFF && !mode_rsv) begin
        if (mode_plain) begin
          link[i] = 1'b1;
          if (match[i]) begin
            case (com_sel[i])
              COM_TOGGLE: next_oc[i] = ~cur.oc[i];
              COM_CLEAR:  next_oc[i] = 1'b0;
              COM_SET:    next_oc[i] = 1'b1;
              default:    next_oc[i] = cur.oc[i];
            endcase
          end
        end else if (com_sel[i] == COM_TOGGLE) begin
          // channel B code 01 is reserved in both PWM modes
          if (i == 0 && cur.top_bit) begin
            link[i] = 1'b1;
            if (match[i])
              next_oc[i] = ~cur.oc[i];
          end
        end else if (mode_fast) begin
          link[i] = 1'b1;
          if (at_bottom)
            next_oc[i] = ~com_sel[i][0];
          if (match[i] && !eq_top)
            next_oc[i] = com_sel[i][0];
        end else begin
          link[i] = 1'b1;
          if (eq_top) begin
            if (at_top)
              next_oc[i] = ~com_sel[i][0];
          end else if (match[i]) begin
            if (cur.dir == COUNT_UP)
              next_oc[i] = com_sel[i][0];
            else
              next_oc[i] = ~com_sel[i][0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // counter, compare buffers, flags and register port
  // ----------------------------------------------------------------
  logic       load_cmp;
  logic       overflow;
  logic [2:0] events;
  logic [2:0] clear_bits;

  // compare values load from the buffer at TOP in both PWM modes so
  // that fast PWM sees them from BOTTOM onward; loading one cycle early
  // costs nothing since the count at TOP never matches a new value yet
  always_comb begin
    case (waveform_mode_select)
      MODE_PHASE_FF, MODE_PHASE_A, MODE_FAST_FF, MODE_FAST_A:
        load_cmp = at_top;
      default:
        load_cmp = 1'b1;
    endcase
  end

  always_comb begin
    case (waveform_mode_select)
      MODE_PHASE_FF, MODE_PHASE_A:
        overflow = at_bottom && (cur.dir == COUNT_DOWN);
      MODE_FAST_A:
        overflow = at_top;
      default:
        overflow = (cur.count == COUNT_MAX);
    endcase
  end

  assign events     = {match[1], match[0], overflow};
  assign clear_bits = (wr && addr == ADDR_STATUS) ? wdata[2:0] : 3'h0;

  always_comb begin
    next_state = cur;
    next_state.count_written = 1'b0;

    // counting sequence
    if (mode_phase) begin
      case (cur.dir)
        COUNT_UP: begin
          if (at_top) begin
            next_state.dir   = COUNT_DOWN;
            next_state.count = cur.count - 8'h01;
          end else begin
            next_state.count = cur.count + 8'h01;
          end
        end
        COUNT_DOWN: begin
          if (at_bottom) begin
            next_state.dir   = COUNT_UP;
            next_state.count = cur.count + 8'h01;
          end else begin
            next_state.count = cur.count - 8'h01;
          end
        end
        default: next_state.dir = COUNT_UP;
      endcase
    end else begin
      next_state.dir = COUNT_UP;
      if (at_top)
        next_state.count = COUNT_BOTTOM;
      else
        next_state.count = cur.count + 8'h01;
    end

    if (load_cmp) begin
      next_state.cmp_a = cur.cmp_a_buf;
      next_state.cmp_b = cur.cmp_b_buf;
    end

    next_state.oc = next_oc;

    // --------------------------------------------------------------
    // status flags
    // --------------------------------------------------------------
    // status: an event in the clearing cycle keeps its bit set
    next_state.status = (cur.status & ~clear_bits) | events;

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    // a write lands on the next edge; a counter write wins over the
    // counting step above, and its following match is suppressed
    if (wr) begin
      case (addr)
        ADDR_CTRL_A: next_state.ctrl_a = wdata & CTRL_A_WMASK;
        ADDR_CTRL_B: next_state.top_bit = wdata[TOP_BIT_POS];
        ADDR_CMP_A: begin
          next_state.cmp_a_buf = wdata;
          if (mode_plain || mode_rsv)
            next_state.cmp_a = wdata;
        end
        ADDR_CMP_B: begin
          next_state.cmp_b_buf = wdata;
          if (mode_plain || mode_rsv)
            next_state.cmp_b = wdata;
        end
        ADDR_COUNT: begin
          next_state.count         = wdata;
          next_state.count_written = 1'b1;
        end
        ADDR_MASK:   next_state.mask = wdata[2:0];
        default:     next_state.mask = cur.mask;
      endcase
    end

    // --------------------------------------------------------------
    // pin drive
    // --------------------------------------------------------------
    // pins: the port keeps the pin while the channel is unlinked
    // the pin is registered, so port data reaches it one cycle late
    for (int k = 0; k < 2; k++) begin
      next_state.pin[k]      = link[k] ? next_oc[k] : port_data[k];
      next_state.pin_oe_n[k] = ~port_dir[k];
    end

    // --------------------------------------------------------------
    // read port
    // --------------------------------------------------------------
    // read data stand for one cycle only and return to zero after, so
    // a stale value can never be taken for a later read
    next_state.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_CTRL_A: next_state.rdata = cur.ctrl_a & CTRL_A_WMASK;
        ADDR_CTRL_B: next_state.rdata = {4'h0, cur.top_bit, 3'h0};
        ADDR_CMP_A:  next_state.rdata = cur.cmp_a_buf;
        ADDR_CMP_B:  next_state.rdata = cur.cmp_b_buf;
        ADDR_COUNT:  next_state.rdata = cur.count;
        ADDR_STATUS: next_state.rdata = {5'h00, cur.status};
        ADDR_MASK:   next_state.rdata = {5'h00, cur.mask};
        default:     next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      cur           <= '0;
      cur.ctrl_a    <= RESET_VALUE;
      cur.pin_oe_n  <= 2'h3;
    end else begin
      cur <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata                = cur.rdata;
  assign compare_output_pin_a = cur.pin[0];
  assign compare_output_pin_b = cur.pin[1];
  assign pin_oe_n_a           = cur.pin_oe_n[0];
  assign pin_oe_n_b           = cur.pin_oe_n[1];
  assign irq                  = |(cur.status & cur.mask);

endmodule : timer8_wave

// [tb/pin_load.sv]
// port pin logic and external load beside one compare output
`timescale 1ns/1ps
module pin_load (
  input  wire logic clk,
  input  wire logic want_dir,
  input  wire logic want_data,
  input  wire logic pin,
  input  wire logic oe_n,
  output logic      port_dir = 1'b0,
  output logic      port_data = 1'b0,
  output logic      pad
);
  // software must make the pin an output before the driver turns on
  always @(posedge clk) begin
    port_dir  <= want_dir;
    port_data <= want_data;
  end
  // internal pull-up holds the pad high while the driver is off
  assign pad = oe_n ? 1'b1 : pin;
endmodule : pin_load

// [tb/timer8_wave_asserts.sv]
// port-level concurrent checks for the waveform timer
`timescale 1ns/1ps
module timer8_wave_asserts
  import timer8_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       port_data_a,
  input wire logic       port_data_b,
  input wire logic       port_dir_a,
  input wire logic       port_dir_b,
  input wire logic       compare_output_pin_a,
  input wire logic       compare_output_pin_b,
  input wire logic       pin_oe_n_a,
  input wire logic       pin_oe_n_b,
  input wire logic       irq
);
  logic [1:0] live;
  logic [7:0] ctrl;
  logic       top;
  logic [2:0] mode;
  logic [1:0] fa;
  logic [1:0] fb;

  // ---------------------------------------------------------------
  // shadow of the control fields, taken from the bus writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live <= 2'h0;
      ctrl <= 8'h00;
      top  <= 1'b0;
    end else begin
      if (live != 2'h3) begin
        live <= live + 2'h1;
      end
      if (wr && addr == ADDR_CTRL_A) begin
        ctrl <= wdata & CTRL_A_WMASK;
      end
      if (wr && addr == ADDR_CTRL_B) begin
        top <= wdata[TOP_BIT_POS];
      end
    end
  end
  assign mode = {top, ctrl[1:0]};
  assign fa   = ctrl[7:6];
  assign fb   = ctrl[5:4];

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // live waits out the two-flop reset release inside the design
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn || live != 2'h3);

  sequence s_ctrl_read;
    rd && addr == ADDR_CTRL_A;
  endsequence
  sequence s_bad_read;
    rd && (addr < ADDR_CTRL_A || addr > ADDR_MASK);
  endsequence

  a_ctrl_rsv_zero: assert property (s_ctrl_read |=> rdata[3:2] == 2'h0)
    else $error("control reserved bits read nonzero");
  a_ctrl_readback: assert property (s_ctrl_read |=> rdata == $past(ctrl))
    else $error("control register readback wrong");
  a_bad_read_zero: assert property (s_bad_read |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pass_port_a: assert property (fa == COM_OFF |=> compare_output_pin_a == $past(port_data_a))
    else $error("pin a not port value while unlinked");
  a_pass_port_b: assert property (fb == COM_OFF |=> compare_output_pin_b == $past(port_data_b))
    else $error("pin b not port value while unlinked");
  a_rsv_mode_off: assert property ((mode == MODE_RSV_4 || mode == MODE_RSV_6) |=> compare_output_pin_a == $past(port_data_a) && compare_output_pin_b == $past(port_data_b))
    else $error("reserved mode left a pin linked");
  a_pwm_a_off: assert property (mode[0] && !top && fa == COM_TOGGLE |=> compare_output_pin_a == $past(port_data_a))
    else $error("pwm field 01 linked pin a");
  a_pwm_b_rsv: assert property (mode[0] && fb == COM_TOGGLE |=> compare_output_pin_b == $past(port_data_b))
    else $error("pwm reserved field linked pin b");
  a_oe_dir_follow: assert property (pin_oe_n_a == !$past(port_dir_a) && pin_oe_n_b == !$past(port_dir_b))
    else $error("output enable not from direction bit");
  a_irq_masked: assert property (wr && addr == ADDR_MASK && wdata == 8'h00 |=> !irq)
    else $error("irq high with mask cleared");
endmodule : timer8_wave_asserts

bind timer8_wave timer8_wave_asserts i_chk (.*);

// [tb/timer8_wave_tb_top.sv]
// self-checking bench for the waveform timer
`timescale 1ns/1ps
module timer8_wave_tb_top;
  import timer8_pkg::*;
  logic       clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, seen;
  logic       want_dir = 1'b0, rd_q = 1'b0, irq;
  logic [1:0] want_data = 2'h0;
  logic       port_data_a, port_data_b, port_dir_a, port_dir_b, pad_a, pad_b;
  logic       compare_output_pin_a, compare_output_pin_b;
  logic       pin_oe_n_a, pin_oe_n_b;
  logic [8:0] exp_q[$];
  logic [2:0] modes[6] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h5, 3'h7};
  int         error_cnt = 0, n_checks = 0, cycles = 0;

  timer8_wave i_timer8_wave (.*);
  pin_load i_pin_load_a (.clk(clk), .want_dir(want_dir),
    .want_data(want_data[0]), .pin(compare_output_pin_a),
    .oe_n(pin_oe_n_a), .port_dir(port_dir_a), .port_data(port_data_a),
    .pad(pad_a));
  pin_load i_pin_load_b (.clk(clk), .want_dir(want_dir),
    .want_data(want_data[1]), .pin(compare_output_pin_b),
    .oe_n(pin_oe_n_b), .port_dir(port_dir_b), .port_data(port_data_b),
    .pad(pad_b));

  always #12.5 clk = ~clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  // bit 8 of the note says whether the read value is compared
  task automatic bus_rd(input logic [7:0] a, input logic [8:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : bus_rd

  // ---------------------------------------------------------------
  // read monitor and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      error_cnt++;
      close_out();
    end
    if (rd_q) begin
      seen = rdata;
      if (exp_q[0][8]) check(rdata, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
    rd_q <= rd;
  end

  initial begin
    logic [7:0] cnt;
    logic [1:0] pw;
    logic [2:0] md;
    logic       ea;
    logic       eb;
    void'($urandom(38));
    fork
      forever begin
        @(posedge clk);
        want_data <= 2'($urandom);
      end
    join_none
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    want_dir <= 1'b1;
    bus_rd(ADDR_CTRL_A, 9'h100);
    bus_wr(ADDR_CTRL_A, 8'hFC);
    bus_rd(ADDR_CTRL_A, 9'h1F0);
    bus_rd(8'h10, 9'h100);
    #1 check({6'h0, pin_oe_n_a, pin_oe_n_b}, 8'h00);
    $display("register test done");
    bus_wr(ADDR_CMP_A, 8'hC0);
    bus_wr(ADDR_CMP_B, 8'h40);
    bus_rd(ADDR_CMP_A, 9'h1C0);
    bus_wr(ADDR_CTRL_A, 8'h50);
    repeat (300) @(posedge clk);
    #1 ea = pad_a;
    eb = pad_b;
    repeat (256) @(posedge clk);
    #1 check({6'h0, pad_a, pad_b}, {6'h0, ~ea, ~eb});
    // pwm field 01 in mode 3 and reserved mode 6 leave the pins to the port; in mode 7 field 01 toggles pin a
    bus_wr(ADDR_CTRL_A, 8'h53);
    repeat (20) @(posedge clk);
    bus_wr(ADDR_CTRL_B, 8'h08);
    repeat (20) @(posedge clk);
    bus_wr(ADDR_CTRL_A, 8'h52);
    repeat (20) @(posedge clk);
    $display("toggle and reserved test done");
    for (int i = 0; i < 12; i++) begin
      md = modes[i / 2];
      pw = 2'(2 + i % 2);
      bus_wr(ADDR_CTRL_B, {4'h0, md[2], 3'h0});
      bus_wr(ADDR_CTRL_A, {pw, pw, 2'h0, md[1:0]});
      repeat (600) @(posedge clk);
      repeat (4) begin
        repeat ($urandom_range(90, 1)) @(posedge clk);
        bus_rd(ADDR_COUNT, 9'h000);
        #1 ea = pad_a;
        eb = pad_b;
        @(posedge clk);
        #1 cnt = seen;
        // all PWM modes switch at a match (phase modes on both slopes), so skip samples near one
        if (md[0] && cnt inside {[8'h3E:8'h42], [8'hBE:8'hC2]}) continue;
        if (!md[0]) check({6'h0, ea, eb}, {6'h0, pw[0], pw[0]});
        else if (md[2]) check({6'h0, ea, eb}, {6'h0, ~pw[0], (cnt < 8'h40) ^ pw[0]});
        else check({6'h0, ea, eb}, {6'h0, (cnt < 8'hC0) ^ pw[0], (cnt < 8'h40) ^ pw[0]});
      end
    end
    $display("waveform table test done");
    bus_wr(ADDR_MASK, 8'h01);
    repeat (300) @(posedge clk);
    #1 check({7'h0, irq}, 8'h01);
    bus_rd(ADDR_STATUS, 9'h107);
    bus_wr(ADDR_MASK, 8'h00);
    bus_wr(ADDR_CTRL_B, 8'h00);
    bus_wr(ADDR_CTRL_A, 8'h00);
    bus_wr(ADDR_COUNT, 8'h10);
    bus_wr(ADDR_STATUS, 8'h07);
    bus_rd(ADDR_STATUS, 9'h100);
    repeat (3) @(posedge clk);
    #1 check({7'h0, irq}, 8'h00);
    $display("interrupt test done");
    close_out();
  end
endmodule : timer8_wave_tb_top
